/* File: common/sar_adc_map.svh */
// register offsets, field positions, reset values and timing counts of the converter
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// ==========================================
// register byte offsets
`define ADC_OFS_MAIN     12'h000
`define ADC_OFS_PORTREF  12'h004
`define ADC_OFS_CFG      12'h008
`define ADC_OFS_RESHI    12'h00C
`define ADC_OFS_RESLO    12'h010
`define ADC_OFS_FLAG     12'h014

// ==========================================
// field positions
`define ADC_ON_BIT       0
`define ADC_GO_BIT       1
`define ADC_FMT_BIT      7
`define ADC_ACQ_HI       5
`define ADC_ACQ_LO       3
`define ADC_CLK_HI       2
`define ADC_CLK_LO       0
`define ADC_REFPOS_BIT   4
`define ADC_REFNEG_BIT   5
`define ADC_FLAG_BIT     0

// ==========================================
// reset values and write masks
`define ADC_MAIN_RST     2'h0
`define ADC_PORTREF_RST  6'h00
`define ADC_CFG_RST      8'h00
`define ADC_CFG_WMASK    8'hBF

// ==========================================
// timing
`define ADC_CLK_NS       8
`define ADC_TCY_NS       32
`define ADC_TCY_CYCLES   ((`ADC_TCY_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_GAP_TAD      2
`define ADC_CONV_TAD     11

`endif

/* File: common/sar_adc_pkg.sv */
// types and decode functions shared by the converter sequencer files
package sar_adc_pkg;

    typedef enum logic [4:0] {
        ST_SAMPLE = 5'b00001,
        ST_RCWAIT = 5'b00010,
        ST_ACQ    = 5'b00100,
        ST_CONV   = 5'b01000,
        ST_GAP    = 5'b10000
    } seq_state_t;

    typedef struct packed {
        logic       enable;
        logic       sampleEn;
        logic       refPosPin;
        logic       refNegPin;
        logic [9:0] dacCode;
    } analog_ctrl_t;

    // codes x11 pick the private rc clock
    function automatic logic is_rc(input logic [2:0] sel);
        return sel[1:0] == 2'b11;
    endfunction

    // last divider count for each oscillator code
    function automatic logic [5:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h0:    div_last = 6'h01;
            3'h1:    div_last = 6'h07;
            3'h2:    div_last = 6'h1F;
            3'h4:    div_last = 6'h03;
            3'h5:    div_last = 6'h0F;
            3'h6:    div_last = 6'h3F;
            default: div_last = 6'h00;
        endcase
    endfunction

    // bit periods of automatic acquisition
    function automatic logic [4:0] acq_tads(input logic [2:0] sel);
        case (sel)
            3'h0:    acq_tads = 5'h00;
            3'h1:    acq_tads = 5'h02;
            3'h2:    acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0C;
            3'h6:    acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction

endpackage

/* File: rtl/tad_tick_gen.sv */
// bit period tick generator: oscillator divider or private rc clock edges
`timescale 1ns/1ps
module tad_tick_gen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] clkSel,
    input  wire logic       rcRise,
    // one pulse per bit period
    output logic            tick
);
    logic [5:0] divCnt_r;
    wire  [5:0] divEnd = sar_adc_pkg::div_last(clkSel);
    wire        rcMode = sar_adc_pkg::is_rc(clkSel);

    // [RL3] divider or rc edge
    assign tick = run && (rcMode ? rcRise : (divCnt_r == divEnd));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= 6'h00;
        end else if (!run || tick || rcMode) begin
            divCnt_r <= 6'h00;
        end else begin
            divCnt_r <= divCnt_r + 6'h01;
        end
    end
endmodule

/* File: rtl/sar_step_engine.sv */
// successive approximation register: one decision per bit period
`timescale 1ns/1ps
module sar_step_engine (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       active,
    input  wire logic       tick,
    input  wire logic       compHigh,
    // results
    output logic [9:0]      dacCode,
    output logic            done
);
    logic [3:0] step_r;
    logic [9:0] trial_r;
    logic       done_r;
    wire  [3:0] bitPos = 4'(4'hA - step_r);
    wire  [3:0] nextPos = 4'(bitPos - 4'h1);

    assign dacCode = trial_r;
    assign done    = done_r;

    // [RL7] keep or drop trial bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_r  <= 4'h0;
            trial_r <= 10'h000;
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (!active) begin
                step_r  <= 4'h0;
                trial_r <= 10'h000;
            end else if (tick && step_r <= 4'hA) begin
                step_r <= step_r + 4'h1;
                if (step_r == 4'h0) begin
                    trial_r <= 10'h200;
                end else begin
                    trial_r[bitPos] <= compHigh;
                    if (bitPos != 4'h0) begin
                        trial_r[nextPos] <= 1'b1;
                    end
                end
                // [RL21] eleven bit periods
                if (step_r == 4'hA) begin
                    done_r <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: rtl/sar_adc_sequencer.sv */
// apb register file and acquisition/conversion sequencer of the 10-bit converter
// ==========================================
// Overview of operation
// [RL1] format bit 7 set gives right justified result, clear gives left
// [RL2] acquisition codes 000..111 give 0,2,4,6,8,12,16,20 bit periods
// [RL3] clock codes pick oscillator /2,/8,/32,/4,/16,/64 or rc for x11
// [RL4] rc clock selected: wait one instruction cycle before bit clock starts
// [RL5] references come from supply rails or reference pins per software
// [RL6] software selects rc clock before starting when sleeping
// [RL7] result built by successive approximation of the held sample
// [RL8] on completion load result pair, clear go/done, set done flag
// [RL9] reset clears registers, turns converter off, aborts conversion
// [RL10] result pair is not initialised by reset
// [RL11] after conversion wait at least two bit periods before acquisition
// [RL12] conversion start disconnects the holding capacitor
// [RL13] acquisition code 000: go/done starts conversion at once
// [RL14] nonzero code: keep sampling programmed periods, then convert
// [RL15] after completion sampling of the selected input resumes by itself
// [RL16] no status separates acquisition from conversion; go/done set across both
// [RL17] software configures, enables, sets go/done, waits, then reads result
// [RL18] configuration bit 6 ignores writes, reads zero; others reset to zero
// [RL19] main control bit 1 is go/done busy, bit 0 enables converter
// [RL20] clearing go/done mid conversion aborts, result pair kept
// [RL21] each conversion takes eleven bit periods
// [RL22] unused six bits of the justified result pair read zero
`timescale 1ns/1ps
`include "sar_adc_map.svh"
module sar_adc_sequencer (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // analog side
    input  wire logic                      compIn,
    input  wire logic                      rcClkIn,
    output sar_adc_pkg::analog_ctrl_t      anaCtrl,
    // status level
    output logic                           convDoneFlag
);

    // ==========================================
    // register select
    function automatic logic [5:0] reg_sel(input logic [11:0] a);
        reg_sel = {a == `ADC_OFS_FLAG, a == `ADC_OFS_RESLO,
                   a == `ADC_OFS_RESHI, a == `ADC_OFS_CFG,
                   a == `ADC_OFS_PORTREF, a == `ADC_OFS_MAIN};
    endfunction

    // [RL1] justify the ten bit result
    function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
        // [RL22] unused bits zero
        justify = right ? {6'h00, r} : {r, 6'h00};
    endfunction

    sar_adc_pkg::seq_state_t state_r;
    sar_adc_pkg::seq_state_t stateNxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cntNxt;
    logic        on_r;
    logic        go_r;
    logic [5:0]  portRef_r;
    logic [7:0]  cfg_r;
    logic [7:0]  resHigh_r;
    logic [7:0]  resLow_r;
    logic        flag_r;
    logic [31:0] prdata_r;
    logic        compS1_r;
    logic        rcS1_r;
    logic        rcS2_r;
    logic        rcS3_r;
    logic        tick;
    logic        engDone;
    logic [9:0]  dacCode;

    // ==========================================
    // apb decode
    wire        setup   = psel && !penable;
    wire        access  = psel && penable;
    wire [5:0]  rdSel   = reg_sel(paddr);
    wire        mapped  = |rdSel;
    wire        wrEn    = access && pwrite && mapped;
    wire        wrMain  = wrEn && rdSel[0];
    wire        wrPort  = wrEn && rdSel[1];
    wire        wrCfg   = wrEn && rdSel[2];
    wire        wrResHi = wrEn && rdSel[3];
    wire        wrResLo = wrEn && rdSel[4];
    wire        wrFlag  = wrEn && rdSel[5];

    assign pready  = psel;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_r;

    wire [2:0]  acqSel  = cfg_r[`ADC_ACQ_HI:`ADC_ACQ_LO];
    wire [2:0]  clkSel  = cfg_r[`ADC_CLK_HI:`ADC_CLK_LO];
    wire [4:0]  acqLast = 5'(sar_adc_pkg::acq_tads(acqSel) - 5'h01);
    wire        acqZero = (acqSel == 3'h0);
    wire        rcSel   = sar_adc_pkg::is_rc(clkSel);
    wire        rcRise  = rcS2_r && !rcS3_r;

    // [RL19] go/done and enable
    wire [31:0] mainRd  = {30'h0000_0000, go_r, on_r};
    wire [31:0] portRd  = {26'h000_0000, portRef_r};
    wire [31:0] cfgRd   = {24'h00_0000, cfg_r};
    wire [31:0] resHiRd = {24'h00_0000, resHigh_r};
    wire [31:0] resLoRd = {24'h00_0000, resLow_r};
    wire [31:0] flagRd  = {31'h0000_0000, flag_r};

    wire [31:0] rdMux = ({32{rdSel[0]}} & mainRd)
                      | ({32{rdSel[1]}} & portRd)
                      | ({32{rdSel[2]}} & cfgRd)
                      | ({32{rdSel[3]}} & resHiRd)
                      | ({32{rdSel[4]}} & resLoRd)
                      | ({32{rdSel[5]}} & flagRd);

    // read data is captured in setup, shown in access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_r <= rdMux;
        end
    end

    // ==========================================
    // comparator gets one stage: it follows our dac code, and /2 leaves no room for two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compS1_r <= 1'b0;
            rcS1_r   <= 1'b0;
            rcS2_r   <= 1'b0;
            rcS3_r   <= 1'b0;
        end else begin
            compS1_r <= compIn;
            rcS1_r   <= rcClkIn;
            rcS2_r   <= rcS1_r;
            rcS3_r   <= rcS2_r;
        end
    end

    // ==========================================
    // control registers
    // [RL9] reset clears control state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_r      <= 1'b0;
            portRef_r <= `ADC_PORTREF_RST;
            cfg_r     <= `ADC_CFG_RST;
        end else begin
            if (wrMain) begin
                on_r <= pwdata[`ADC_ON_BIT];
            end
            if (wrPort) begin
                portRef_r <= pwdata[5:0];
            end
            // [RL18] bit 6 ignores writes
            if (wrCfg) begin
                cfg_r <= pwdata[7:0] & `ADC_CFG_WMASK;
            end
        end
    end

    // [RL16] go/done spans both phases; set only once already enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            go_r <= 1'b0;
        // [RL8] completion clears go/done
        end else if (engDone || !on_r) begin
            go_r <= 1'b0;
        end else if (wrMain) begin
            go_r <= pwdata[`ADC_GO_BIT] && pwdata[`ADC_ON_BIT];
        end
    end

    // [RL8] done flag, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (engDone) begin
            flag_r <= 1'b1;
        end else if (wrFlag) begin
            flag_r <= pwdata[`ADC_FLAG_BIT];
        end
    end
    assign convDoneFlag = flag_r;

    // ==========================================
    // result pair
    wire [15:0] resFmt = justify(dacCode, cfg_r[`ADC_FMT_BIT]);

    // [RL10] no reset on purpose: contents undefined until loaded
    always_ff @(posedge clk) begin
        // [RL8] load on completion
        if (engDone) begin
            resHigh_r <= resFmt[15:8];
            resLow_r  <= resFmt[7:0];
        end else begin
            if (wrResHi) begin
                resHigh_r <= pwdata[7:0];
            end
            if (wrResLo) begin
                resLow_r <= pwdata[7:0];
            end
        end
    end

    // ==========================================
    // sequencer
    wire inConv = (state_r == sar_adc_pkg::ST_CONV);
    wire busy   = (state_r == sar_adc_pkg::ST_RCWAIT)
               || (state_r == sar_adc_pkg::ST_ACQ) || inConv;
    wire runTad = (state_r == sar_adc_pkg::ST_ACQ) || inConv
               || (state_r == sar_adc_pkg::ST_GAP);

    always_comb begin
        stateNxt = state_r;
        cntNxt   = cnt_r;
        case (state_r)
            sar_adc_pkg::ST_SAMPLE: begin
                cntNxt = 5'h00;
                if (go_r && on_r) begin
                    // [RL4] rc clock waits one instruction cycle
                    if (rcSel) begin
                        stateNxt = sar_adc_pkg::ST_RCWAIT;
                    // [RL13] code 000 converts at once
                    end else if (acqZero) begin
                        stateNxt = sar_adc_pkg::ST_CONV;
                    // [RL14] programmed acquisition first
                    end else begin
                        stateNxt = sar_adc_pkg::ST_ACQ;
                    end
                end
            end
            sar_adc_pkg::ST_RCWAIT: begin
                if (cnt_r == 5'(`ADC_TCY_CYCLES - 1)) begin
                    cntNxt   = 5'h00;
                    stateNxt = acqZero ? sar_adc_pkg::ST_CONV : sar_adc_pkg::ST_ACQ;
                end else begin
                    cntNxt = cnt_r + 5'h01;
                end
            end
            sar_adc_pkg::ST_ACQ: begin
                // [RL2] count programmed bit periods
                if (tick && cnt_r == acqLast) begin
                    cntNxt   = 5'h00;
                    stateNxt = sar_adc_pkg::ST_CONV;
                end else if (tick) begin
                    cntNxt = cnt_r + 5'h01;
                end
            end
            sar_adc_pkg::ST_CONV: begin
                cntNxt = 5'h00;
                if (engDone) begin
                    stateNxt = sar_adc_pkg::ST_GAP;
                end
            end
            sar_adc_pkg::ST_GAP: begin
                // [RL11] two bit periods idle
                if (tick && cnt_r == 5'(`ADC_GAP_TAD - 1)) begin
                    cntNxt   = 5'h00;
                    // [RL15] back to sampling
                    stateNxt = sar_adc_pkg::ST_SAMPLE;
                end else if (tick) begin
                    cntNxt = cnt_r + 5'h01;
                end
            end
            default: begin
                stateNxt = sar_adc_pkg::ST_SAMPLE;
                cntNxt   = 5'h00;
            end
        endcase
        // [RL20] go/done cleared mid run aborts
        if (busy && !go_r && !engDone) begin
            stateNxt = sar_adc_pkg::ST_GAP;
            cntNxt   = 5'h00;
        end
        // [RL9] converter off aborts at once
        if (!on_r) begin
            stateNxt = sar_adc_pkg::ST_SAMPLE;
            cntNxt   = 5'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= sar_adc_pkg::ST_SAMPLE;
            cnt_r   <= 5'h00;
        end else begin
            state_r <= stateNxt;
            cnt_r   <= cntNxt;
        end
    end

    // ==========================================
    // bit period and approximation
    tad_tick_gen u_tick (
        .clk    (clk),
        .rst    (rst),
        .run    (runTad),
        .clkSel (clkSel),
        .rcRise (rcRise),
        .tick   (tick)
    );

    sar_step_engine u_sar (
        .clk      (clk),
        .rst      (rst),
        .active   (inConv && go_r),
        .tick     (tick),
        .compHigh (compS1_r),
        .dacCode  (dacCode),
        .done     (engDone)
    );

    // ==========================================
    // analog controls
    // [RL12] holding capacitor off once conversion starts
    wire sampling = on_r && ((state_r == sar_adc_pkg::ST_SAMPLE)
                  || (state_r == sar_adc_pkg::ST_ACQ)
                  || ((state_r == sar_adc_pkg::ST_RCWAIT) && !acqZero));

    assign anaCtrl.enable   = on_r;
    assign anaCtrl.sampleEn = sampling;
    // [RL5] reference source select
    assign anaCtrl.refPosPin = portRef_r[`ADC_REFPOS_BIT];
    assign anaCtrl.refNegPin = portRef_r[`ADC_REFNEG_BIT];
    assign anaCtrl.dacCode   = dacCode;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_done_clears_go: assert property (engDone |=> !go_r) // [RL8]
        else $error("go/done still set after completion");
    a_done_sets_flag: assert property (engDone |=> flag_r) // [RL8]
        else $error("done flag not set after completion");
    a_conv_no_sample: assert property (inConv |-> !anaCtrl.sampleEn) // [RL12]
        else $error("sampling during conversion");
    a_gap_on_done: assert property (engDone && on_r |=> state_r == sar_adc_pkg::ST_GAP) // [RL11]
        else $error("no idle gap after conversion");
    a_zero_acq_start: assert property ( // [RL13]
        state_r == sar_adc_pkg::ST_SAMPLE && go_r && on_r && acqZero && !rcSel
        |=> inConv)
        else $error("conversion not started at once");
    a_off_aborts_run: assert property ($fell(on_r) |=> state_r == sar_adc_pkg::ST_SAMPLE) // [RL9]
        else $error("converter off did not abort");
    a_abort_keeps_result: assert property ( // [RL20]
        !engDone && !wrResHi && !wrResLo |=> $stable({resHigh_r, resLow_r}))
        else $error("result pair changed without completion");
    a_cfg_bit6_zero: assert property (cfg_r[6] == 1'b0) // [RL18]
        else $error("reserved configuration bit set");
    a_go_while_busy: assert property (busy && on_r && !engDone |-> go_r || $past(go_r)) // [RL16]
        else $error("go/done low during acquisition or conversion");
    a_conv_eleven_tad: assert property ( // [RL21]
        $rose(inConv) && !rcSel && clkSel == 3'h0 && go_r |-> ##22 engDone || !go_r)
        else $error("conversion length wrong");

    c_conv_done:   cover property (engDone);
    c_acq_to_conv: cover property (state_r == sar_adc_pkg::ST_ACQ ##1 inConv);
    c_abort:       cover property (inConv && !go_r);
endmodule

/* File: tb/analog_front_model.sv */
// comparator, holding capacitor and private rc oscillator facing the converter
`timescale 1ns/1ps
module analog_front_model (
    // converter side
    input  wire sar_adc_pkg::analog_ctrl_t anaCtrl,
    output logic                           compIn,
    output logic                           rcClkIn,
    // level at the selected input pin
    input  wire logic [9:0]                level
);
    logic [9:0] held;
    // rc clock for sleep
    // runs free, 40 ns period, kept off the clk edges
    initial begin
        rcClkIn = 1'b0;
        #2;
        forever #20 rcClkIn = ~rcClkIn;
    end
    // cap follows the pin only while connected
    always @* if (anaCtrl.sampleEn) held = level;
    // half lsb offset: final code equals the held level
    assign compIn = anaCtrl.enable ? (held >= anaCtrl.dacCode) : 1'b0;
endmodule

/* File: tb/sar_adc_sequencer_bench.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`include "sar_adc_map.svh"
module sar_adc_sequencer_bench;
    logic                      clk;
    logic                      rst;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      compIn;
    logic                      rcClkIn;
    sar_adc_pkg::analog_ctrl_t anaCtrl;
    logic                      convDoneFlag;
    logic [9:0]                level;
    logic [31:0]               q;
    logic                      err;
    logic [9:0]                v;
    logic [7:0]                cfg;
    int                        fails;
    int                        checked;
    int                        cyc;
    int                        lowCnt;
    int                        minLow;
    int                        t0;
    int                        n;
    // bit period in clocks per clock code; rc oscillator gives 5
    int divT[8] = '{2, 8, 32, 5, 4, 16, 64, 5};
    int acq_time_sel[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    sar_adc_sequencer i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compIn(compIn), .rcClkIn(rcClkIn), .anaCtrl(anaCtrl),
        .convDoneFlag(convDoneFlag));
    analog_front_model i_front (.anaCtrl(anaCtrl), .compIn(compIn), .rcClkIn(rcClkIn),
        .level(level));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================
    // checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            fails++;
            close_out();
        end
    endtask

    // ==========================================
    // apb master: one idle edge between transfers
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        guard(k, 16);
    endtask

    task automatic wait_sample;
        n = 0;
        while (anaCtrl.sampleEn !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        guard(n, 3000);
    endtask

    // ==========================================
    // sampling gap monitor: low stretch is conversion plus gap
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (anaCtrl.sampleEn !== 1'b1)
            lowCnt <= lowCnt + 1;
        else begin
            if (lowCnt > 0 && anaCtrl.enable === 1'b1)
                check("gap", lowCnt >= minLow, 1);
            lowCnt <= 0;
        end
    end

    task automatic convert(input int i);
        cfg = {i[0], 1'b0, i[2:0], i[2:0]};
        v = 10'(i * 131 + 5);
        wait_sample();
        level <= v;
        apb(1'b1, `ADC_OFS_CFG, {24'h0000_00, cfg});
        apb(1'b1, `ADC_OFS_FLAG, 32'h0000_0000);
        minLow = 13 * divT[i] - 1;
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0003);
        t0 = cyc;
        apb(1'b0, `ADC_OFS_MAIN, 32'h0000_0000);
        check("busy", q, 32'h0000_0003);
        n = 0;
        do begin
            apb(1'b0, `ADC_OFS_MAIN, 32'h0000_0000);
            n++;
        end while (q[1] !== 1'b0 && n < 2000);
        guard(n, 2000);
        n = cyc - t0;
        check("time lo", n >= (acq_time_sel[i] + 11) * divT[i], 1);
        check("time hi", n <= (acq_time_sel[i] + 12) * divT[i] + 24, 1);
        apb(1'b0, `ADC_OFS_RESHI, 32'h0000_0000);
        check("high", q, cfg[7] ? {30'h0, v[9:8]} : {24'h0000_00, v[9:2]});
        apb(1'b0, `ADC_OFS_RESLO, 32'h0000_0000);
        check("low", q, cfg[7] ? {24'h0000_00, v[7:0]} : {24'h0000_00, v[1:0], 6'h00});
        apb(1'b0, `ADC_OFS_FLAG, 32'h0000_0000);
        check("flag", q, 32'h0000_0001);
        check("flag pin", convDoneFlag, 1);
        $display("test convert %0d done", i);
    endtask

    // ==========================================
    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        level = 10'h000;
        fails = 0;
        checked = 0;
        cyc = 0;
        lowCnt = 0;
        minLow = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `ADC_OFS_CFG, 32'h0000_0000);
        check("cfg reset", q, 32'h0000_0000);
        apb(1'b0, `ADC_OFS_MAIN, 32'h0000_0000);
        check("main reset", q, 32'h0000_0000);
        apb(1'b1, `ADC_OFS_CFG, 32'h0000_00FF);
        apb(1'b0, `ADC_OFS_CFG, 32'h0000_0000);
        check("cfg bit6", q, 32'h0000_00BF);
        apb(1'b0, 12'h018, 32'h0000_0000);
        check("unmapped", {err, q[30:0]}, 32'h8000_0000);
        apb(1'b1, `ADC_OFS_PORTREF, 32'h0000_0030);
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0001);
        #1;
        check("refs", {anaCtrl.refPosPin, anaCtrl.refNegPin}, 2'b11);
        check("enable", anaCtrl.enable, 1);
        $display("test registers done");
        // every clock and acquisition code once, rc codes included
        for (int i = 0; i < 8; i++)
            convert(i);
        wait_sample();
        apb(1'b1, `ADC_OFS_CFG, 32'h0000_0086);
        apb(1'b1, `ADC_OFS_FLAG, 32'h0000_0000);
        level <= 10'h155;
        minLow = 127;
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0003);
        repeat (200) @(posedge clk);
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0001);
        apb(1'b0, `ADC_OFS_MAIN, 32'h0000_0000);
        check("abort go", q, 32'h0000_0001);
        apb(1'b0, `ADC_OFS_RESLO, 32'h0000_0000);
        check("abort low", q, {24'h0000_00, v[7:0]});
        check("abort flag", convDoneFlag, 0);
        $display("test abort done");
        wait_sample();
        minLow = 0;
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0003);
        repeat (50) @(posedge clk);
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0000);
        apb(1'b0, `ADC_OFS_MAIN, 32'h0000_0000);
        check("off abort", {q[1:0], anaCtrl.sampleEn}, 32'h0000_0000);
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0001);
        apb(1'b1, `ADC_OFS_MAIN, 32'h0000_0003);
        repeat (50) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check("off", anaCtrl.enable, 0);
        apb(1'b0, `ADC_OFS_MAIN, 32'h0000_0000);
        check("main cleared", q, 32'h0000_0000);
        apb(1'b0, `ADC_OFS_RESLO, 32'h0000_0000);
        check("result kept", q, {24'h0000_00, v[7:0]});
        $display("test reset done");
        close_out();
    end
endmodule
